// ===== design/link_control_cycle_timer_ctrl.v
`timescale 1ns/1ps
`include "link_ctrl_map.vh"

module link_control_cycle_timer_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire external_cycle_input,
    input wire tx_idle,
    input wire phy_root,
    input wire self_id_done,
    input wire busy_b_next,
    input wire ack_valid,
    input wire [3:0] ack_code,
    input wire async_transmit_fifo_sel,
    input wire cycle_timeout_det,
    input wire iso_pkt_valid,
    input wire iso_in_window,
    output reg iso_pkt_accept,
    output reg iso_pkt_discard,
    output reg cycle_start_req,
    output wire phy_link_if_reset_req,
    input wire phy_if_reset_done,
    output wire [31:0] cycle_time,
    output reg irq
);

////////////////////////////////////////////////////////////////////////////////
// Declarations.

reg strict_iso_filter_en_q;
reg cycle_master_en_q;
reg master_blocked_q;
reg cycle_source_sel_q;
reg cycle_timer_en_q;
reg phy_link_if_reset_req_q;
reg transmitter_ready_q;
reg root_q;
reg next_busy_ack_type_q;
reg [`W_LAST_ASYNC_TX_ACK-1:0] last_async_tx_ack_q;
reg [`W_INT-1:0] int_status_q;
reg [`W_INT-1:0] int_status_d;
reg [`W_INT-1:0] int_mask_q;
reg cyc_in_meta_q;
reg cyc_in_sync_q;
reg cyc_in_prev_q;
wire ext_cycle_rise;
wire access;
wire wr_access;
wire rd_access;
wire addr_hit;
wire wr_ctrl;
wire wr_timer;
wire wr_mask;
wire rd_status;
wire count_inc;
wire [31:0] ctrl_value;
wire [`W_INT-1:0] int_events;
wire send_cycle_start;
wire discard_now;

// Reset image of the general control register; the plain control flops take their own bits, the master enable and reset request reset to zero.
localparam [31:0] rst_ctrl = `RST_CONTROL;

////////////////////////////////////////////////////////////////////////////////
// APB decode.

// The slave never stalls, so every access completes in its first access cycle.
assign access = psel & penable;
assign wr_access = access & pwrite;
assign rd_access = access & ~pwrite;
assign addr_hit = (paddr == `OFS_LINK_GENERAL_CONTROL) | (paddr == `OFS_CYCLE_TIMER) |
                  (paddr == `OFS_INT_STATUS) | (paddr == `OFS_INT_MASK);
assign pready = 1'b1;
assign pslverr = access & ~addr_hit; // Unmapped addresses answer with an error.
assign wr_ctrl = wr_access & (paddr == `OFS_LINK_GENERAL_CONTROL);
assign wr_timer = wr_access & (paddr == `OFS_CYCLE_TIMER);
assign wr_mask = wr_access & (paddr == `OFS_INT_MASK);
assign rd_status = rd_access & (paddr == `OFS_INT_STATUS);

////////////////////////////////////////////////////////////////////////////////
// External cycle input synchroniser and edge detect.

// Two flops before use; the edge detector only looks at the second stage.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cyc_in_meta_q <= 1'b0;
        cyc_in_sync_q <= 1'b0;
        cyc_in_prev_q <= 1'b0;
    end else begin
        cyc_in_meta_q <= external_cycle_input;
        cyc_in_sync_q <= cyc_in_meta_q;
        cyc_in_prev_q <= cyc_in_sync_q;
    end
end

assign ext_cycle_rise = cyc_in_sync_q & ~cyc_in_prev_q;

////////////////////////////////////////////////////////////////////////////////
// Cycle timer.

cycle_timer_core u_cycle_timer_core (
    .pclk(pclk),
    .presetn(presetn),
    .timer_en(cycle_timer_en_q),
    .source_sel(cycle_source_sel_q),
    .ext_cycle_rise(ext_cycle_rise),
    .wr_en(wr_timer),
    .wr_data(pwdata),
    .timer_value(cycle_time),
    .count_inc(count_inc)
);

////////////////////////////////////////////////////////////////////////////////
// Host writable control bits.

// Plain control bits of the general control register.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        strict_iso_filter_en_q <= rst_ctrl[`BIT_STRICT_ISO_FILTER_EN];
        cycle_source_sel_q <= rst_ctrl[`BIT_CYCLE_SOURCE_SEL];
        cycle_timer_en_q <= rst_ctrl[`BIT_CYCLE_TIMER_EN];
    end else if (wr_ctrl) begin
        strict_iso_filter_en_q <= pwdata[`BIT_STRICT_ISO_FILTER_EN];
        cycle_source_sel_q <= pwdata[`BIT_CYCLE_SOURCE_SEL];
        cycle_timer_en_q <= pwdata[`BIT_CYCLE_TIMER_EN];
    end
end

// Cycle master enable. A timeout clears it and blocks it; only a written zero
// lifts the block, so a stray rewrite of one cannot restart a faulty master.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cycle_master_en_q <= 1'b0;
        master_blocked_q <= 1'b0;
    end else if (cycle_timeout_det) begin
        cycle_master_en_q <= 1'b0;
        master_blocked_q <= 1'b1;
    end else if (wr_ctrl) begin
        if (!pwdata[`BIT_CYCLE_MASTER_EN]) begin
            cycle_master_en_q <= 1'b0;
            master_blocked_q <= 1'b0;
        end else if (!master_blocked_q) begin
            cycle_master_en_q <= 1'b1;
        end
    end
end

// Interface reset request. Completion has priority so the bit cannot stick.
// Software must drain the async queues first; the block does not check that.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        phy_link_if_reset_req_q <= 1'b0;
    end else if (phy_if_reset_done) begin
        phy_link_if_reset_req_q <= 1'b0;
    end else if (wr_ctrl && pwdata[`BIT_PHY_LINK_IF_RESET_REQ]) begin
        phy_link_if_reset_req_q <= 1'b1;
    end
end

assign phy_link_if_reset_req = phy_link_if_reset_req_q;

////////////////////////////////////////////////////////////////////////////////
// Status capture.

// Live status is registered once so a read sees a stable value.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        transmitter_ready_q <= 1'b0;
        next_busy_ack_type_q <= 1'b0;
    end else begin
        transmitter_ready_q <= tx_idle;
        next_busy_ack_type_q <= busy_b_next;
    end
end

// Root status changes only when self identification has finished.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        root_q <= 1'b0;
    end else if (self_id_done) begin
        root_q <= phy_root;
    end
end

// Acks for packets outside the async FIFO path are not recorded.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        last_async_tx_ack_q <= `RST_ACK_CODE;
    end else if (ack_valid && async_transmit_fifo_sel) begin
        last_async_tx_ack_q <= ack_code;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Cycle start and isochronous filter.

// A cycle start follows every count step while this node is the root master.
assign send_cycle_start = cycle_master_en_q & root_q & count_inc;
assign discard_now = iso_pkt_valid & strict_iso_filter_en_q & ~iso_in_window;

// One-cycle request pulses toward the transmitter and receiver.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cycle_start_req <= 1'b0;
        iso_pkt_accept <= 1'b0;
        iso_pkt_discard <= 1'b0;
    end else begin
        cycle_start_req <= send_cycle_start;
        iso_pkt_accept <= iso_pkt_valid & ~discard_now;
        iso_pkt_discard <= discard_now;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupts.

assign int_events = {cycle_timeout_det, 2'b00, phy_if_reset_done, discard_now,
                     send_cycle_start};

// Read clears the sticky bits; an event in the same cycle is kept.
always @* begin
    int_status_d = int_status_q;
    if (rd_status) begin
        int_status_d = {`W_INT{1'b0}};
    end
    int_status_d = int_status_d | int_events;
end

// Sticky status and its mask.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        int_status_q <= {`W_INT{1'b0}};
        int_mask_q <= `RST_INT_MASK;
    end else begin
        int_status_q <= int_status_d;
        if (wr_mask) begin
            int_mask_q <= pwdata[`W_INT-1:0];
        end
    end
end

// Level interrupt, registered to keep the output glitch free.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq <= 1'b0;
    end else begin
        irq <= |(int_status_d & int_mask_q);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data.

assign ctrl_value = {13'h0000, phy_link_if_reset_req_q, 5'h00, strict_iso_filter_en_q,
                     cycle_master_en_q, cycle_source_sel_q, cycle_timer_en_q, 2'b00,
                     transmitter_ready_q, root_q, next_busy_ack_type_q,
                     last_async_tx_ack_q};

// Read data is registered in the setup cycle so it is valid in the access phase.
// Status is taken from its next value: an event in the setup cycle is reported
// here rather than wiped unseen by the clear at the access edge.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
        case (paddr)
            `OFS_LINK_GENERAL_CONTROL: prdata <= ctrl_value;
            `OFS_CYCLE_TIMER: prdata <= cycle_time;
            `OFS_INT_STATUS: prdata <= {26'h0000000, int_status_d};
            `OFS_INT_MASK: prdata <= {26'h0000000, int_mask_q};
            default: prdata <= 32'h0000_0000;
        endcase
    end
end

endmodule

// ===== pkg/link_ctrl_map.vh
`ifndef LINK_CTRL_MAP_VH
`define LINK_CTRL_MAP_VH

// Register byte offsets.
`define OFS_LINK_GENERAL_CONTROL 12'h004
`define OFS_CYCLE_TIMER 12'h010
`define OFS_INT_STATUS 12'h020
`define OFS_INT_MASK 12'h024

// General control field positions.
`define BIT_PHY_LINK_IF_RESET_REQ 18
`define BIT_STRICT_ISO_FILTER_EN 12
`define BIT_CYCLE_MASTER_EN 11
`define BIT_CYCLE_SOURCE_SEL 10
`define BIT_CYCLE_TIMER_EN 9
`define BIT_TRANSMITTER_READY 6
`define BIT_ROOT 5
`define BIT_NEXT_BUSY_ACK_TYPE 4
`define LSB_LAST_ASYNC_TX_ACK 0
`define W_LAST_ASYNC_TX_ACK 4

// Interrupt status and mask field positions.
`define INT_CYCLE_START_SENT 0
`define INT_ISO_DISCARDED 1
`define INT_PHY_IF_RESET_DONE 2
`define INT_CYCLE_TIMEOUT_STATUS 5
`define W_INT 6

// Cycle timer field layout.
`define LSB_CYCLE_OFFSET 0
`define W_CYCLE_OFFSET 12
`define LSB_CYCLE_COUNT 12
`define W_CYCLE_COUNT 13
`define LSB_CYCLE_SECONDS 25
`define W_CYCLE_SECONDS 7
`define CYCLE_OFFSET_MAX 12'hbff
`define CYCLE_COUNT_MAX 13'h1f3f

// Reset values.
`define RST_CONTROL 32'h0000_0000
`define RST_CYCLE_TIMER 32'h0000_0000
`define RST_INT_MASK 6'h00
`define RST_ACK_CODE 4'h0

`endif

// ===== design/cycle_timer_core.v
`timescale 1ns/1ps
`include "link_ctrl_map.vh"

module cycle_timer_core (
    input wire pclk,
    input wire presetn,
    input wire timer_en,
    input wire source_sel,
    input wire ext_cycle_rise,
    input wire wr_en,
    input wire [31:0] wr_data,
    output wire [31:0] timer_value,
    output wire count_inc
);

reg [`W_CYCLE_OFFSET-1:0] offset_q;
reg [`W_CYCLE_COUNT-1:0] count_q;
reg [`W_CYCLE_SECONDS-1:0] seconds_q;
reg [`W_CYCLE_OFFSET-1:0] offset_d;
reg [`W_CYCLE_COUNT-1:0] count_d;
reg [`W_CYCLE_SECONDS-1:0] seconds_d;
reg inc_d;
wire offset_wrap;

// Reset image of the whole timer word, split per field at reset.
localparam [31:0] rst_timer = `RST_CYCLE_TIMER;

////////////////////////////////////////////////////////////////////////////////

assign offset_wrap = (offset_q == `CYCLE_OFFSET_MAX);

// Next timer value; a host write always wins so the register doubles as scratch storage.
always @* begin
    offset_d = offset_q;
    count_d = count_q;
    seconds_d = seconds_q;
    inc_d = 1'b0;
    if (wr_en) begin
        offset_d = wr_data[`LSB_CYCLE_OFFSET +: `W_CYCLE_OFFSET];
        count_d = wr_data[`LSB_CYCLE_COUNT +: `W_CYCLE_COUNT];
        seconds_d = wr_data[`LSB_CYCLE_SECONDS +: `W_CYCLE_SECONDS];
    end else if (timer_en) begin
        if (source_sel) begin
            if (ext_cycle_rise) begin
                offset_d = {`W_CYCLE_OFFSET{1'b0}};
                inc_d = 1'b1;
            end else if (!offset_wrap) begin
                offset_d = offset_q + 1'b1;
            end
        end else begin
            if (offset_wrap) begin
                offset_d = {`W_CYCLE_OFFSET{1'b0}};
                inc_d = 1'b1;
            end else begin
                offset_d = offset_q + 1'b1;
            end
        end
        if (inc_d) begin
            if (count_q == `CYCLE_COUNT_MAX) begin
                count_d = {`W_CYCLE_COUNT{1'b0}};
                seconds_d = seconds_q + 1'b1;
            end else begin
                count_d = count_q + 1'b1;
            end
        end
    end
end

// Timer state.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        offset_q <= rst_timer[`LSB_CYCLE_OFFSET +: `W_CYCLE_OFFSET];
        count_q <= rst_timer[`LSB_CYCLE_COUNT +: `W_CYCLE_COUNT];
        seconds_q <= rst_timer[`LSB_CYCLE_SECONDS +: `W_CYCLE_SECONDS];
    end else begin
        offset_q <= offset_d;
        count_q <= count_d;
        seconds_q <= seconds_d;
    end
end

assign timer_value = {seconds_q, count_q, offset_q};
assign count_inc = inc_d;

endmodule

// ===== sim/phy_model.sv
`timescale 1ns/1ps

module phy_model (
    input wire pclk,
    input wire presetn,
    input wire reset_req,
    input wire [3:0] lat,
    output reg reset_done
);
    reg [3:0] cnt_q;

    // Finishes an interface reset lat+1 cycles after the request, so prompt and slow PHYs play.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            reset_done <= 1'b0;
        end else begin
            reset_done <= reset_req && cnt_q == lat;
            cnt_q <= reset_req ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule

// ===== sim/link_ctrl_sva.sv
`timescale 1ns/1ps
`include "link_ctrl_map.vh"

module link_ctrl_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire phy_root,
    input wire self_id_done,
    input wire cycle_timeout_det,
    input wire iso_pkt_valid,
    input wire iso_in_window,
    input wire iso_pkt_accept,
    input wire iso_pkt_discard,
    input wire cycle_start_req,
    input wire phy_link_if_reset_req,
    input wire phy_if_reset_done,
    input wire [31:0] cycle_time
);
    reg [3:0] ctl_q;
    reg root_q;
    reg [1:0] quiet_q;
    reg blk_q;
    wire wr = psel && penable && pwrite;
    wire ctl_wr = wr && paddr == `OFS_LINK_GENERAL_CONTROL;
    wire tim_wr = wr && paddr == `OFS_CYCLE_TIMER;
    wire [11:0] ofs = cycle_time[11:0];
    wire mst_root = ctl_q[2] && root_q;
    wire run = quiet_q == 2'h3 && ctl_q[0] && !ctl_q[1];
    wire still = quiet_q == 2'h3 && !ctl_q[0];

    // Host copy of control bits 12:9; timer checks wait three quiet cycles since host writes win.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 4'h0;
            root_q <= 1'b0;
            quiet_q <= 2'h0;
            blk_q <= 1'b0;
        end else begin
            // Timeout block mirror: a timeout sets it, only a written master enable of 0 lifts it.
            if (cycle_timeout_det) begin
                blk_q <= 1'b1;
            end else if (ctl_wr && !pwdata[11]) begin
                blk_q <= 1'b0;
            end
            if (ctl_wr) begin
                ctl_q <= pwdata[12:9];
            end
            if (self_id_done) begin
                root_q <= phy_root;
            end
            quiet_q <= (ctl_wr || tim_wr) ? 2'h0 : quiet_q + {1'b0, quiet_q != 2'h3};
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_keep; iso_pkt_valid && (iso_in_window || !ctl_q[3]) |=> iso_pkt_accept; endproperty
    a_keep: assert property (p_keep) else $error("iso packet dropped");
    property p_drop; iso_pkt_valid && !iso_in_window && ctl_q[3] |=> iso_pkt_discard; endproperty
    a_drop: assert property (p_drop) else $error("iso packet kept");
    property p_start; cycle_start_req |-> $past(mst_root); endproperty
    a_start: assert property (p_start) else $error("start without master");
    property p_tmo; blk_q && $past(blk_q) |-> !cycle_start_req; endproperty
    a_tmo: assert property (p_tmo) else $error("start after timeout");
    property p_hold; still |-> $stable(cycle_time); endproperty
    a_hold: assert property (p_hold) else $error("timer moved while off");
    property p_inc; run && $past(ofs) != 12'hbff |-> ofs == $past(ofs) + 12'h1; endproperty
    a_inc: assert property (p_inc) else $error("offset step wrong");
    property p_wrap;
        run && $past(ofs) == 12'hbff |-> ofs == 12'h0 && $changed(cycle_time[24:12]);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap wrong");
    property p_rpl; phy_if_reset_done |=> !phy_link_if_reset_req; endproperty
    a_rpl: assert property (p_rpl) else $error("reset request stuck");

    c_start: cover property (cycle_start_req);
    c_drop: cover property (iso_pkt_discard);
    c_rpl: cover property (phy_link_if_reset_req ##[1:10] phy_if_reset_done);
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
`include "link_ctrl_map.vh"

module testbench;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, err, ext_in, tx_idle, phy_root, sid_done, busy_b;
    logic ack_valid, fifo_sel, tmo, iso_v, iso_win;
    logic [11:0] paddr;
    logic [31:0] pwdata, r, v;
    logic [3:0] ack_code, lat, k;
    logic [19:0] c;
    wire [31:0] prdata, ctime;
    wire pready, pslverr, acc, dis, csr, rreq, rdone, irq;
    int fails = 0;
    int comparisons = 0;
    int n, i;
    localparam logic [11:0] ctl = `OFS_LINK_GENERAL_CONTROL;
    localparam logic [11:0] tim = `OFS_CYCLE_TIMER;

    // Free-running clock, 10 ns period.
    always #5 pclk = ~pclk;

    link_control_cycle_timer_ctrl dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .external_cycle_input(ext_in), .tx_idle, .phy_root, .self_id_done(sid_done),
        .busy_b_next(busy_b), .ack_valid, .ack_code, .async_transmit_fifo_sel(fifo_sel),
        .cycle_timeout_det(tmo), .iso_pkt_valid(iso_v), .iso_in_window(iso_win),
        .iso_pkt_accept(acc), .iso_pkt_discard(dis), .cycle_start_req(csr),
        .phy_link_if_reset_req(rreq), .phy_if_reset_done(rdone), .cycle_time(ctime), .irq
    );
    phy_model phy (.pclk, .presetn, .reset_req(rreq), .lat, .reset_done(rdone));

    ////////////////////////////////////////
    // Prints the counts and the verdict; every ending path comes here.
    task stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Compares, counts and reports.
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask

    // A wait that ran out counts as a mismatch and ends the run.
    task bound(input int m);
        if (n >= m) begin
            chk("wait", 32'h0, 32'h1);
            stop_test;
        end
    endtask

    // One APB transfer; the request holds until pready is sampled high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        bound(20);
        r = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    // One-cycle pulse on {sid_done, tmo, iso_v, ack_valid}, launched just after an edge.
    task pulse(input logic [3:0] m);
        {sid_done, tmo, iso_v, ack_valid} <= m;
        @(posedge pclk);
        {sid_done, tmo, iso_v, ack_valid} <= 4'h0;
    endtask

    // Seconds and count after one count step; the count wraps at its top.
    function automatic logic [19:0] step(input logic [19:0] t);
        return t[12:0] == `CYCLE_COUNT_MAX ? {t[19:13] + 7'h1, 13'h0} : t + 20'h1;
    endfunction

    ////////////////////////////////////////
    // Main sequence.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ext_in, tx_idle, phy_root} = '0;
        {sid_done, busy_b, ack_valid, fifo_sel, ack_code, tmo, iso_v, iso_win, k} = '0;
        lat = 4'h1;
        v = $urandom(32'h5f57);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ctl, 32'h0);
        chk("ctl", `RST_CONTROL, r);
        apb(1'b0, 12'h0fc, 32'h0);
        chk("hole", 32'h1, {r[30:0], err});
        // A stopped timer is plain storage.
        v = $urandom;
        apb(1'b1, tim, v);
        repeat (6) @(posedge pclk);
        apb(1'b0, tim, 32'h0);
        chk("store", v, r);
        // Offset wrap carries into the count, first at the top count.
        c = {7'h11, `CYCLE_COUNT_MAX};
        for (i = 0; i < 2; i++) begin
            apb(1'b1, tim, {c, 12'hbf0});
            apb(1'b1, ctl, 32'h200);
            for (n = 0; n < 60 && ctime[11:0] >= 12'h10; n++) @(posedge pclk);
            bound(60);
            chk("carry", step(c), ctime[31:12]);
            apb(1'b1, ctl, 32'h0);
            c = {7'h2, 13'($urandom % 32'h1f3f)};
        end
        // An external edge steps the count and restarts the offset.
        apb(1'b1, ctl, 32'h600);
        repeat (4) @(posedge pclk);
        c = ctime[31:12];
        ext_in <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("ext", {step(c), 12'h0}, {ctime[31:12], ctime[11:4], 4'h0});
        ext_in <= 1'b0;
        // Root master sends starts until a timeout, which holds until cleared and set.
        phy_root <= 1'b1;
        pulse(4'h8);
        apb(1'b1, `OFS_INT_MASK, 32'h20);
        apb(1'b1, tim, 32'hbf0);
        apb(1'b1, ctl, 32'ha00);
        for (n = 0; n < 60 && csr !== 1'b1; n++) @(posedge pclk);
        bound(60);
        pulse(4'h4);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h1, irq);
        apb(1'b0, `OFS_INT_STATUS, 32'h0);
        chk("tmo", 32'h21, r);
        apb(1'b0, `OFS_INT_STATUS, 32'h0);
        chk("clear", 32'h0, r);
        apb(1'b0, ctl, 32'h0);
        chk("off", 32'h0, {irq, r[11]});
        apb(1'b1, ctl, 32'ha00);
        apb(1'b0, ctl, 32'h0);
        chk("held", 32'h0, r[11]);
        apb(1'b1, ctl, 32'h200);
        apb(1'b1, ctl, 32'ha00);
        apb(1'b0, ctl, 32'h0);
        chk("rearm", 32'h3, {r[11], r[5]});
        apb(1'b1, `OFS_INT_MASK, 32'h0);
        pulse(4'h4);
        repeat (2) @(posedge pclk);
        chk("mask", 32'h0, irq);
        // Strict filter against the window, all four ways.
        for (i = 0; i < 4; i++) begin
            apb(1'b1, ctl, 32'(i[1]) << 12);
            iso_win <= i[0];
            pulse(4'h2);
            #1;
            chk("iso", {!i[1] || i[0], i[1] && !i[0]}, {acc, dis});
        end
        // Random levels and acks; an ack is kept only while the FIFO is selected.
        apb(1'b1, ctl, 32'h0);
        for (i = 0; i < 6; i++) begin
            v = $urandom;
            {tx_idle, busy_b, fifo_sel, ack_code} <= v[6:0];
            @(posedge pclk);
            pulse(4'h1);
            if (v[4]) k = v[3:0];
            repeat (2) @(posedge pclk);
            apb(1'b0, ctl, 32'h0);
            chk("stat", {25'h0, v[6], 1'b1, v[5], k}, r);
        end
        // Interface reset request against a prompt and a slow PHY.
        for (i = 1; i < 9; i += 7) begin
            lat <= 4'(i);
            // The bench queues no async traffic, so both async queues are empty here.
            apb(1'b1, ctl, 32'h4_0000);
            @(posedge pclk);
            chk("rplset", 32'h1, rreq);
            repeat (11) @(posedge pclk);
            apb(1'b0, ctl, 32'h0);
            chk("rpl", 32'h0, r[18]);
        end
        stop_test;
    end
endmodule

bind link_control_cycle_timer_ctrl link_ctrl_sva sva (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .phy_root, .self_id_done,
    .cycle_timeout_det, .iso_pkt_valid, .iso_in_window, .iso_pkt_accept, .iso_pkt_discard,
    .cycle_start_req, .phy_link_if_reset_req, .phy_if_reset_done, .cycle_time
);
